// File: src/pcictl_defs.svh
// constants for the bus control signalling block: commands, timing
// assumes nothing; definitions only
`ifndef PCICTL_DEFS_SVH
`define PCICTL_DEFS_SVH
// bus command codes on the command/byte-enable lanes
`define PCICTL_CMD_MEM_READ   4'h6
`define PCICTL_CMD_MEM_WRITE  4'h7
// target decode window: upper address bits that select the device
`define PCICTL_BAR_BASE       16'hF000
`define PCICTL_BAR_HI         31
`define PCICTL_BAR_LO         16
// clock figures; period of the bus clock in ns
`define PCICTL_CLK_NS         100
// stop after this many data phases in one burst (disconnect)
`define PCICTL_BURST_MAX      4'h8
`endif

// File: src/pcictl_device.sv
// device end: bus target with parity checking and open-drain outputs
// assumes the host end keeps the initiator side of the protocol
//
// How it works
// - master holds frame while more phases follow
// - phase completes when both readies sampled low
// - either ready high inserts a wait cycle
// - read: initiator ready only when accepting
// - write: initiator ready only with valid data
// - read: target ready only driving valid data
// - write: target ready only when accepting
// - target stop makes master end access
// - data parity mismatch raises parity error
// - address parity error pulls system error low
// - interrupt line pulled low while request pending
// - control lines driven only by owner
// - address phase is first frame-low cycle
// - even parity, valid one clock later
`timescale 1ns/1ns
`default_nettype none
`include "pcictl_defs.svh"
module pcictl_device (
    // clock and reset
    input  wire logic         CLK,
    input  wire logic         RST_B,
    input  wire logic         CE,
    // bus side
    pcictl_if.device          BUS,
    // internal capture side
    input  wire logic [31:0]  RD_DATA,
    input  wire logic         RD_VALID,
    input  wire logic         WR_ACCEPT,
    input  wire logic         IRQ_PEND,
    output logic       [31:0] WR_DATA,
    output logic       [3:0]  WR_BE,
    output logic              WR_STB,
    output logic              RD_STB,
    output logic              PAR_ERR
);
    import pcictl_pkg::*;

    // ****************************************
    // decode and parity
    // ****************************************
    logic        frame_q_reg;
    logic        chk_addr_reg;
    logic        chk_data_reg;
    logic        par_calc_reg;
    logic        is_write_reg;
    logic        data_phase_reg;
    logic [3:0]  burst_reg;
    logic        trdy_reg;
    logic        stop_reg;
    logic        devsel_reg;
    logic        ad_oe_reg;
    logic [31:0] ad_reg;
    logic        par_oe_reg;
    logic        par_reg;
    logic        perr_reg;
    logic        perr_oe_reg;
    logic        serr_reg;
    logic        inta_reg;
    pct_tstate_t st_reg;
    pct_tstate_t st_next;

    // address phase is first cycle frame seen low
    wire addr_phase = !BUS.frame_n_i && frame_q_reg;
    wire hit = BUS.ad_i[`PCICTL_BAR_HI:`PCICTL_BAR_LO] == `PCICTL_BAR_BASE;
    wire cmd_rd = BUS.cbe_i == `PCICTL_CMD_MEM_READ;
    wire cmd_wr = BUS.cbe_i == `PCICTL_CMD_MEM_WRITE;
    wire claim  = addr_phase && hit && (cmd_rd || cmd_wr);
    wire xfer   = !BUS.irdy_n_i && trdy_reg;
    wire last   = BUS.frame_n_i;
    wire par_in = ^{BUS.ad_i, BUS.cbe_i};
    wire par_bad = par_calc_reg != BUS.par_i;
    // read data ready only when the source offers it
    wire rd_go  = !is_write_reg && RD_VALID;
    wire wr_go  = is_write_reg && WR_ACCEPT;
    // count the phase finishing now, so ready drops right after the last
    wire [3:0] burst_cnt = burst_reg + {3'h0, xfer};
    wire stop_want = burst_cnt >= `PCICTL_BURST_MAX;

    // next target state
    always_comb begin
        case (st_reg)
            PCT_IDLE: st_next = claim ? PCT_DATA : PCT_IDLE;
            PCT_DATA: st_next = (xfer || stop_reg) && last ? PCT_TURN
                                                            : PCT_DATA;
            PCT_TURN: st_next = PCT_IDLE;
            default:  st_next = PCT_IDLE;
        endcase
    end

    // ****************************************
    // state and handshake flops
    // ****************************************
    // parity is delayed one clock, so remember what the bus carried
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            frame_q_reg  <= 1'b1;
            chk_addr_reg <= 1'b0;
            chk_data_reg <= 1'b0;
            par_calc_reg <= 1'b0;
        end else if (CE) begin
            frame_q_reg  <= BUS.frame_n_i;
            chk_addr_reg <= addr_phase;
            chk_data_reg <= is_write_reg && xfer;
            par_calc_reg <= par_in;
        end
    end

    // target handshake; sustained lines are driven high one turn cycle
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            st_reg     <= PCT_IDLE;
            is_write_reg <= 1'b0;
            burst_reg  <= 4'h0;
            trdy_reg   <= 1'b0;
            stop_reg   <= 1'b0;
            devsel_reg <= 1'b0;
            data_phase_reg <= 1'b0;
        end else if (CE) begin
            st_reg <= st_next;
            if (claim) begin
                is_write_reg <= cmd_wr;
                burst_reg    <= 4'h0;
            end else if (xfer) begin
                burst_reg <= burst_reg + 4'h1;
            end
            devsel_reg <= st_next == PCT_DATA;
            data_phase_reg <= st_next != PCT_IDLE;
            // hold ready low while waiting; drop it after the last completion
            trdy_reg <= (st_next == PCT_DATA) && !stop_want && !claim
                        && !(xfer && last) && (rd_go || wr_go);
            // old burst count is stale on a new claim, so mask it
            stop_reg <= (st_next == PCT_DATA) && stop_want
                        && !claim;
        end
    end

    // read data, parity drive and error outputs
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ad_reg      <= 32'h0;
            ad_oe_reg   <= 1'b0;
            par_reg     <= 1'b0;
            par_oe_reg  <= 1'b0;
            perr_reg    <= 1'b0;
            perr_oe_reg <= 1'b0;
            serr_reg    <= 1'b0;
            inta_reg    <= 1'b0;
            WR_DATA     <= 32'h0;
            WR_BE       <= 4'h0;
            WR_STB      <= 1'b0;
            RD_STB      <= 1'b0;
            PAR_ERR     <= 1'b0;
        end else if (CE) begin
            ad_reg     <= RD_DATA;
            ad_oe_reg  <= (st_next == PCT_DATA) && !is_write_reg
                          && !claim;
            // target drives parity one clock after its read data
            par_reg    <= ^{ad_reg, BUS.cbe_i};
            par_oe_reg <= ad_oe_reg;
            perr_reg   <= chk_data_reg && par_bad;
            perr_oe_reg <= chk_data_reg || perr_reg;
            serr_reg   <= chk_addr_reg && par_bad;
            inta_reg   <= IRQ_PEND;
            WR_STB     <= is_write_reg && xfer;
            RD_STB     <= !is_write_reg && xfer && st_reg == PCT_DATA;
            WR_DATA    <= BUS.ad_i;
            WR_BE      <= ~BUS.cbe_i;
            PAR_ERR    <= (chk_data_reg || chk_addr_reg) && par_bad;
        end
    end

    // ****************************************
    // pin drive
    // ****************************************
    // open-drain: output low only, enable carries the pull
    assign BUS.serr_n_oe   = serr_reg;
    assign BUS.inta_n_oe   = inta_reg;
    assign BUS.trdy_n_o    = !trdy_reg;
    assign BUS.trdy_n_oe   = data_phase_reg;
    assign BUS.devsel_n_o  = !devsel_reg;
    assign BUS.devsel_n_oe = data_phase_reg;
    assign BUS.stop_n_o    = !stop_reg;
    assign BUS.stop_n_oe   = data_phase_reg;
    assign BUS.ad_t_o      = ad_reg;
    assign BUS.ad_t_oe     = ad_oe_reg;
    assign BUS.par_t_o     = par_reg;
    assign BUS.par_t_oe    = par_oe_reg;
    assign BUS.perr_n_t_o  = !perr_reg;
    assign BUS.perr_n_t_oe = perr_oe_reg;
endmodule // pcictl_device
`default_nettype wire

// File: src/pcictl_host.sv
// host end: a bus initiator doing single or burst memory accesses
// assumes the device end answers as a target on the same interface
`timescale 1ns/1ns
`default_nettype none
`include "pcictl_defs.svh"
module pcictl_host (
    // clock and reset
    input  wire logic         CLK,
    input  wire logic         RST_B,
    input  wire logic         CE,
    // bus side
    pcictl_if.host            BUS,
    // user command side
    input  wire logic         START,
    input  wire logic         WRITE,
    input  wire logic [31:0]  ADDR,
    input  wire logic [3:0]   LEN,
    input  wire logic [31:0]  WDATA,
    input  wire logic         RD_READY,
    output logic              BUSY,
    output logic       [31:0] RDATA,
    output logic              RD_STB,
    output logic              WR_STB,
    output logic              STOPPED,
    output logic              PAR_ERR
);
    import pcictl_pkg::*;

    // ****************************************
    // sequencing
    // ****************************************
    pct_istate_t st_reg;
    logic        frame_reg;
    logic        irdy_reg;
    logic        own_reg;
    logic        ad_oe_reg;
    logic        wr_reg;
    logic [3:0]  left_reg;
    logic [31:0] ad_reg;
    logic [3:0]  cbe_reg;
    logic        par_reg;
    logic        par_oe_reg;
    logic        chk_reg;
    logic        perr_reg;
    logic        perr_oe_reg;
    logic        lane_par_reg;

    wire xfer    = irdy_reg && !BUS.trdy_n_i;
    wire stopped = !BUS.stop_n_i && !BUS.devsel_n_i;
    wire last    = left_reg == 4'h0 || stopped;
    // read: only ready when user can take data; write: data is on lanes
    wire can_go  = wr_reg ? 1'b1 : RD_READY;
    // parity trails the lanes by a clock, so compare against last lanes
    wire par_bad = lane_par_reg != BUS.par_i;

    // initiator flow
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            st_reg    <= PCI_IDLE;
            frame_reg <= 1'b0;
            irdy_reg  <= 1'b0;
            own_reg   <= 1'b0;
            ad_oe_reg <= 1'b0;
            wr_reg    <= 1'b0;
            left_reg  <= 4'h0;
            ad_reg    <= 32'h0;
            cbe_reg   <= 4'h0;
        end else if (CE) begin
            case (st_reg)
                PCI_IDLE: begin
                    if (START) begin
                        st_reg    <= PCI_ADDR;
                        frame_reg <= 1'b1;
                        own_reg   <= 1'b1;
                        ad_oe_reg <= 1'b1;
                        wr_reg    <= WRITE;
                        left_reg  <= LEN;
                        ad_reg    <= ADDR;
                        cbe_reg   <= WRITE ? `PCICTL_CMD_MEM_WRITE
                                           : `PCICTL_CMD_MEM_READ;
                    end
                end
                PCI_ADDR: begin
                    st_reg    <= PCI_DATA;
                    ad_reg    <= WDATA;
                    ad_oe_reg <= wr_reg;
                    cbe_reg   <= 4'h0;
                    irdy_reg  <= can_go;
                    frame_reg <= left_reg != 4'h0 || !can_go;
                end
                PCI_DATA: begin
                    if (stopped) begin
                        frame_reg <= 1'b0;
                    end
                    if (stopped && !frame_reg && !xfer) begin
                        // disconnect without data: frame already gone
                        st_reg    <= PCI_TURN;
                        irdy_reg  <= 1'b0;
                        ad_oe_reg <= 1'b0;
                    end else if (xfer) begin
                        if (last || !frame_reg) begin
                            st_reg   <= PCI_TURN;
                            irdy_reg <= 1'b0;
                            frame_reg <= 1'b0;
                            ad_oe_reg <= 1'b0;
                        end else begin
                            left_reg  <= left_reg - 4'h1;
                            ad_reg    <= WDATA;
                            frame_reg <= left_reg != 4'h1 || !can_go;
                            irdy_reg  <= can_go;
                        end
                    end else begin
                        irdy_reg <= irdy_reg || can_go;
                        // frame may only drop once ready is up
                        if (can_go && left_reg == 4'h0) begin
                            frame_reg <= 1'b0;
                        end
                    end
                end
                PCI_TURN: begin
                    st_reg  <= PCI_IDLE;
                    own_reg <= 1'b0;
                end
                default: st_reg <= PCI_IDLE;
            endcase
        end
    end

    // parity drive a clock behind lanes; check read data parity
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            par_reg     <= 1'b0;
            par_oe_reg  <= 1'b0;
            chk_reg     <= 1'b0;
            perr_reg    <= 1'b0;
            perr_oe_reg <= 1'b0;
            lane_par_reg <= 1'b0;
            BUSY        <= 1'b0;
            RDATA       <= 32'h0;
            RD_STB      <= 1'b0;
            WR_STB      <= 1'b0;
            STOPPED     <= 1'b0;
            PAR_ERR     <= 1'b0;
        end else if (CE) begin
            par_reg     <= ^{ad_reg, cbe_reg};
            par_oe_reg  <= ad_oe_reg;
            lane_par_reg <= ^{BUS.ad_i, BUS.cbe_i};
            chk_reg     <= !wr_reg && xfer;
            perr_reg    <= chk_reg && par_bad;
            perr_oe_reg <= chk_reg || perr_reg;
            BUSY        <= st_reg != PCI_IDLE || START;
            RD_STB      <= !wr_reg && xfer;
            WR_STB      <= wr_reg && xfer;
            if (xfer) begin
                RDATA <= BUS.ad_i;
            end
            STOPPED     <= st_reg == PCI_DATA && stopped && frame_reg;
            PAR_ERR     <= chk_reg && par_bad;
        end
    end

    // ****************************************
    // pin drive
    // ****************************************
    assign BUS.frame_n_o   = !frame_reg;
    assign BUS.frame_n_oe  = own_reg;
    assign BUS.irdy_n_o    = !irdy_reg;
    assign BUS.irdy_n_oe   = own_reg;
    assign BUS.ad_m_o      = ad_reg;
    assign BUS.ad_m_oe     = ad_oe_reg;
    assign BUS.cbe_o       = cbe_reg;
    assign BUS.cbe_oe      = own_reg;
    assign BUS.par_m_o     = par_reg;
    assign BUS.par_m_oe    = par_oe_reg;
    assign BUS.perr_n_m_o  = !perr_reg;
    assign BUS.perr_n_m_oe = perr_oe_reg;
endmodule // pcictl_host
`default_nettype wire

// File: src/pcictl_if.sv
// bus wires shared by the host end and the device end
// assumes the testbench resolves each wire from the enables
`timescale 1ns/1ns
`default_nettype none
interface pcictl_if;
    // shared lanes: each party drives out/oe (cbe: host only), reads resolved value
    logic [31:0] ad_i;
    logic [31:0] ad_m_o;
    logic        ad_m_oe;
    logic [31:0] ad_t_o;
    logic        ad_t_oe;
    logic [3:0]  cbe_i;
    logic [3:0]  cbe_o;
    logic        cbe_oe;
    logic        par_i;
    logic        par_m_o;
    logic        par_m_oe;
    logic        par_t_o;
    logic        par_t_oe;
    // control lines, active low when resolved
    logic        frame_n_i;
    logic        frame_n_o;
    logic        frame_n_oe;
    logic        irdy_n_i;
    logic        irdy_n_o;
    logic        irdy_n_oe;
    logic        trdy_n_i;
    logic        trdy_n_o;
    logic        trdy_n_oe;
    logic        devsel_n_i;
    logic        devsel_n_o;
    logic        devsel_n_oe;
    logic        stop_n_i;
    logic        stop_n_o;
    logic        stop_n_oe;
    logic        perr_n_i;
    logic        perr_n_m_o;
    logic        perr_n_m_oe;
    logic        perr_n_t_o;
    logic        perr_n_t_oe;
    // open-drain outputs of the device
    logic        serr_n_oe;
    logic        inta_n_oe;
    modport host (
        input  ad_i, cbe_i, par_i, frame_n_i, irdy_n_i, trdy_n_i,
        input  devsel_n_i, stop_n_i, perr_n_i, serr_n_oe, inta_n_oe,
        output ad_m_o, ad_m_oe, cbe_o, cbe_oe, par_m_o, par_m_oe,
        output frame_n_o, frame_n_oe, irdy_n_o, irdy_n_oe,
        output perr_n_m_o, perr_n_m_oe
    );
    modport device (
        input  ad_i, cbe_i, par_i, frame_n_i, irdy_n_i, trdy_n_i,
        input  devsel_n_i, stop_n_i, perr_n_i,
        output ad_t_o, ad_t_oe, par_t_o, par_t_oe,
        output trdy_n_o, trdy_n_oe, devsel_n_o, devsel_n_oe,
        output stop_n_o, stop_n_oe, perr_n_t_o, perr_n_t_oe,
        output serr_n_oe, inta_n_oe
    );
endinterface : pcictl_if
`default_nettype wire

// File: src/pcictl_pkg.sv
// types for the bus control signalling block
// assumes pcictl_defs.svh is on the include path
package pcictl_pkg;
    // target state, gray along idle-data-turnaround
    typedef enum logic [1:0] {
        PCT_IDLE = 2'b00,
        PCT_DATA = 2'b01,
        PCT_TURN = 2'b11
    } pct_tstate_t;
    // initiator state, gray along idle-address-data-turnaround
    typedef enum logic [1:0] {
        PCI_IDLE = 2'b00,
        PCI_ADDR = 2'b01,
        PCI_DATA = 2'b11,
        PCI_TURN = 2'b10
    } pct_istate_t;
endpackage : pcictl_pkg

// File: verification/pcictl_props.sv
// checker for the shared bus wires between host end and device end
// assumes resolved wire levels and the enables of both parties
`timescale 1ns/1ns
`default_nettype none
`include "pcictl_defs.svh"
module pcictl_props (
    // clock and reset
    input wire logic        CLK,
    input wire logic        RST_B,
    // resolved lanes
    input wire logic [31:0] ad_i,
    input wire logic [3:0]  cbe_i,
    input wire logic        par_i,
    // parity drivers
    input wire logic        par_m_o,
    input wire logic        par_m_oe,
    input wire logic        par_t_o,
    input wire logic        par_t_oe,
    // control lines
    input wire logic        frame_n_i,
    input wire logic        irdy_n_i,
    input wire logic        trdy_n_i,
    input wire logic        devsel_n_i,
    input wire logic        stop_n_i,
    input wire logic        perr_n_i,
    input wire logic        serr_n_oe,
    input wire logic        ad_m_oe,
    input wire logic        ad_t_oe
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    // ************************************************************
    // properties
    // ************************************************************
    // a phase completes when both readies are low
    sequence s_done;
        !irdy_n_i && !trdy_n_i;
    endsequence
    property p_devsel;
        $fell(frame_n_i) && ad_i[31:16] == `PCICTL_BAR_BASE &&
        (cbe_i == `PCICTL_CMD_MEM_READ || cbe_i == `PCICTL_CMD_MEM_WRITE)
        |=> !devsel_n_i;
    endproperty
    property p_trdy_sel;
        !trdy_n_i |-> !devsel_n_i;
    endproperty
    property p_excl;
        !(ad_m_oe && ad_t_oe) && !(par_m_oe && par_t_oe);
    endproperty
    property p_addr_par;
        $fell(frame_n_i) |=> par_m_oe &&
            par_m_o == ^{$past(ad_i), $past(cbe_i)};
    endproperty
    property p_data_par;
        s_done |=> (par_m_oe || par_t_oe) &&
            (par_m_oe ? par_m_o : par_t_o) == ^{$past(ad_i), $past(cbe_i)};
    endproperty
    // the checking agent raises perr two clocks after the phase
    property p_perr;
        s_done ##1 (par_i != ^{$past(ad_i), $past(cbe_i)}) |=> !perr_n_i;
    endproperty
    property p_serr;
        $fell(frame_n_i) ##1 (par_i != ^{$past(ad_i), $past(cbe_i)})
        |=> serr_n_oe;
    endproperty
    property p_last;
        frame_n_i && !irdy_n_i && !trdy_n_i |=> irdy_n_i && trdy_n_i;
    endproperty
    property p_frame_irdy;
        $rose(frame_n_i) |-> !irdy_n_i;
    endproperty
    // write data must sit still while the target holds off
    property p_wait;
        !irdy_n_i && trdy_n_i && stop_n_i && ad_m_oe
        |=> !irdy_n_i && $stable(ad_i);
    endproperty
    property p_stop;
        !stop_n_i && !frame_n_i |-> ##[1:3] frame_n_i;
    endproperty
    // ************************************************************
    // assertions and covers
    // ************************************************************
    a_devsel: assert property (p_devsel) else $error("no select");
    a_trdy_sel: assert property (p_trdy_sel) else $error("trdy alone");
    a_excl: assert property (p_excl) else $error("two drivers");
    a_addr_par: assert property (p_addr_par) else $error("addr par");
    a_data_par: assert property (p_data_par) else $error("data par");
    a_perr: assert property (p_perr) else $error("perr missing");
    a_serr: assert property (p_serr) else $error("serr missing");
    a_last: assert property (p_last) else $error("no release");
    a_frame_irdy: assert property (p_frame_irdy) else $error("frame");
    a_wait: assert property (p_wait) else $error("wait broken");
    a_stop: assert property (p_stop) else $error("stop ignored");
    c_wr: cover property (s_done ##0 ad_m_oe);
    c_rd: cover property (s_done ##0 ad_t_oe);
    c_stop: cover property (!stop_n_i);
    c_perr: cover property (!perr_n_i);
endmodule : pcictl_props
`default_nettype wire

// File: verification/pcictl_tb_top.sv
// testbench joining the host end and the device end on one bus
// assumes pull-ups on control lines; lanes float when nobody drives
`timescale 1ns/1ns
`default_nettype none
module pcictl_tb_top;
    logic        clk, rst_b, ce, start, write, rd_ready, h_busy;
    logic        rd_valid, wr_accept, irq, par_flip, frame_q;
    logic [3:0]  len;
    logic [31:0] addr, wdata, rd_data, exp_d, fpat, cyc;
    logic        d_wr, d_rd, d_perr, h_wr, h_rd, h_stop, h_perr;
    logic [31:0] d_wdata, h_rdata;
    int          mismatches, n_tests, inj;
    int          dw, dr, hw, hr, stp, dpe, hpe, serr_c, perr_c;
    pcictl_if bus ();
    // ************************************************************
    // wire resolution
    // ************************************************************
    // floating lanes show a moving pattern, not the last value
    assign bus.ad_i = bus.ad_m_oe ? bus.ad_m_o
                    : bus.ad_t_oe ? bus.ad_t_o : fpat;
    assign bus.cbe_i = bus.cbe_oe ? bus.cbe_o : fpat[3:0];
    assign bus.par_i = par_flip ^ (bus.par_m_oe ? bus.par_m_o
                     : bus.par_t_oe ? bus.par_t_o : fpat[0]);
    assign bus.frame_n_i = bus.frame_n_oe ? bus.frame_n_o : 1'b1;
    assign bus.irdy_n_i = bus.irdy_n_oe ? bus.irdy_n_o : 1'b1;
    assign bus.trdy_n_i = bus.trdy_n_oe ? bus.trdy_n_o : 1'b1;
    assign bus.devsel_n_i = bus.devsel_n_oe ? bus.devsel_n_o : 1'b1;
    assign bus.stop_n_i = bus.stop_n_oe ? bus.stop_n_o : 1'b1;
    assign bus.perr_n_i = bus.perr_n_m_oe ? bus.perr_n_m_o
                        : bus.perr_n_t_oe ? bus.perr_n_t_o : 1'b1;
    pcictl_device u_pcictl_device (.CLK(clk), .RST_B(rst_b), .CE(ce),
        .BUS(bus), .RD_DATA(rd_data), .RD_VALID(rd_valid),
        .WR_ACCEPT(wr_accept), .IRQ_PEND(irq), .WR_DATA(d_wdata),
        .WR_BE(), .WR_STB(d_wr), .RD_STB(d_rd), .PAR_ERR(d_perr));
    pcictl_host u_pcictl_host (.CLK(clk), .RST_B(rst_b), .CE(ce),
        .BUS(bus), .START(start), .WRITE(write), .ADDR(addr), .LEN(len),
        .WDATA(wdata), .RD_READY(rd_ready), .BUSY(h_busy),
        .RDATA(h_rdata), .RD_STB(h_rd), .WR_STB(h_wr), .STOPPED(h_stop),
        .PAR_ERR(h_perr));
    pcictl_props u_pcictl_props (.CLK(clk), .RST_B(rst_b),
        .ad_i(bus.ad_i), .cbe_i(bus.cbe_i), .par_i(bus.par_i),
        .par_m_o(bus.par_m_o), .par_m_oe(bus.par_m_oe),
        .par_t_o(bus.par_t_o), .par_t_oe(bus.par_t_oe),
        .frame_n_i(bus.frame_n_i), .irdy_n_i(bus.irdy_n_i),
        .trdy_n_i(bus.trdy_n_i), .devsel_n_i(bus.devsel_n_i),
        .stop_n_i(bus.stop_n_i), .perr_n_i(bus.perr_n_i),
        .serr_n_oe(bus.serr_n_oe), .ad_m_oe(bus.ad_m_oe),
        .ad_t_oe(bus.ad_t_oe));
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic clr;
        {dw, dr, hw, hr, stp, dpe, hpe, serr_c, perr_c} = '0;
    endtask
    // one access; for reads both ends hold off for dly cycles to force waits, for writes only the device end
    task automatic access(input logic w, input logic [3:0] n,
                          input logic [31:0] d, input int dly);
        int i;
        clr();
        exp_d = d;
        wdata = d;
        rd_data = d;
        write = w;
        addr = 32'hF000_0040;
        len = n;
        {rd_valid, wr_accept, rd_ready} = 3'h0;
        start = 1'b1;
        @(posedge clk) #1;
        start = 1'b0;
        for (i = 0; i < 200; i++) begin
            if (i == dly) begin
                if (!w) check(32'(bus.irdy_n_i), 32'h1);
                check(32'(dw + dr), 32'h0);
                {rd_valid, wr_accept, rd_ready} = 3'h7;
            end
            @(posedge clk) #1;
            if (!h_busy && i > dly) break;
        end
        check(32'(h_busy), 32'h0);
    endtask
    // ************************************************************
    // clock, monitors, timeout
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // strobes are registered pulses, so sample them on the edge
    always @(posedge clk) begin
        fpat <= fpat + 32'h1;
        frame_q <= bus.frame_n_i;
        par_flip <= (inj == 1 && !bus.frame_n_i && frame_q) ||
                    (inj == 2 && !bus.irdy_n_i && !bus.trdy_n_i);
        if (d_wr) begin
            dw++;
            check(d_wdata, exp_d);
        end
        if (h_rd) begin
            hr++;
            check(h_rdata, exp_d);
        end
        dr += int'(d_rd);
        hw += int'(h_wr);
        stp += int'(h_stop);
        dpe += int'(d_perr);
        hpe += int'(h_perr);
        serr_c += int'(bus.serr_n_oe);
        perr_c += int'(!bus.perr_n_i);
    end
    // the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 32'h1;
        if (cyc == 32'd3000) begin
            mismatches++;
            final_report();
        end
    end
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        {rst_b, start, write, rd_ready, rd_valid, wr_accept, irq} = '0;
        {ce, par_flip, frame_q} = 3'b110;
        {len, addr, wdata, rd_data, exp_d, fpat, cyc} = '0;
        {mismatches, n_tests, inj} = '0;
        clr();
        repeat (20) @(posedge clk);
        #1;
        check(32'({bus.ad_m_oe, bus.ad_t_oe, bus.frame_n_oe, bus.irdy_n_oe,
            bus.trdy_n_oe, bus.devsel_n_oe, bus.stop_n_oe, bus.serr_n_oe,
            bus.inta_n_oe}), 32'h0);
        rst_b = 1'b1;
        access(1'b1, 4'h0, 32'hA5A5_0001, 3);
        check(32'(dw), 32'h1);
        check(32'(hw), 32'h1);
        access(1'b1, 4'h3, 32'h5A5A_0F0F, 0);
        check(32'(dw), 32'h4);
        access(1'b0, 4'h0, 32'h1234_5678, 4);
        check(32'(dr), 32'h1);
        check(32'(hr), 32'h1);
        access(1'b0, 4'h3, 32'h8765_4321, 0);
        check(32'(hr), 32'h4);
        access(1'b1, 4'hF, 32'hC3C3_3C3C, 0);
        check(32'(dw), 32'h8);
        check(32'(stp), 32'h1);
        access(1'b0, 4'hF, 32'h0F0F_F0F0, 0);
        check(32'(hr), 32'h8);
        inj = 1;
        access(1'b1, 4'h0, 32'h0000_0001, 0);
        check(32'(dpe), 32'h1);
        check(32'(serr_c != 0), 32'h1);
        inj = 2;
        access(1'b1, 4'h0, 32'h0000_0003, 0);
        check(32'(dpe), 32'h1);
        check(32'(perr_c != 0), 32'h1);
        access(1'b0, 4'h0, 32'h0000_0007, 0);
        check(32'(hpe), 32'h1);
        inj = 0;
        irq = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check(32'(bus.inta_n_oe), 32'h1);
        irq = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check(32'(bus.inta_n_oe), 32'h0);
        final_report();
    end
endmodule : pcictl_tb_top
`default_nettype wire
